// *** rtl/acs_sequencer.v ***
// converter timing sequencer with register port
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.vh"
module acs_sequencer (
  input wire clk_sys,
  input wire rst,
  input wire [2:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire trigger,
  input wire [11:0] sample_in,
  output reg [15:0] rdata,
  output reg converter_busy_flag,
  output reg result_ready,
  output reg sample_hold,
  output reg amp_hold,
  output reg [4:0] power_en
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_INIT = 7'h02;
  localparam [6:0] ST_SAMP = 7'h04;
  localparam [6:0] ST_CONV = 7'h08;
  localparam [6:0] ST_LAT = 7'h10;
  localparam [6:0] ST_MAIN = 7'h20;
  localparam [6:0] ST_ACC = 7'h40;

  reg [15:0] main_control_register;
  reg [7:0] sampling_control_register;
  reg [7:0] accumulation_control_register;
  reg [7:0] amplifier_control_register;
  reg [15:0] clk_cfg;
  reg [23:0] result;
  reg [23:0] acc;
  reg [10:0] acc_left;
  reg [6:0] state;
  reg [8:0] half_cnt;
  reg [4:0] warm_set;
  reg init_start;
  reg first;
  reg [4:0] need;
  reg [10:0] acc_total;
  reg [8:0] samp_halves;
  reg [4:0] conv_cycles;
  reg is_acc;

  wire half_tick;
  wire phase;
  wire init_done;
  wire slow_clk;
  wire [2:0] mode;
  wire [1:0] in_sel;
  wire keep_warm_bit;
  wire continuous_conversion_bit;
  wire [7:0] sample_length_field;
  wire [7:0] amp_hold_length_field;
  wire [3:0] accumulation_count_field;
  wire [3:0] clock_divider_field;
  wire [7:0] us_ticks;
  wire cfg_wr;
  wire run_div;

  assign mode = main_control_register[`ACS_MAIN_MODE_HI:`ACS_MAIN_MODE_LO];
  assign in_sel =
    main_control_register[`ACS_MAIN_INSEL_HI:`ACS_MAIN_INSEL_LO];
  assign keep_warm_bit = main_control_register[`ACS_MAIN_WARM];
  assign continuous_conversion_bit =
    accumulation_control_register[`ACS_ACC_FREE];
  assign sample_length_field = sampling_control_register;
  assign amp_hold_length_field = amplifier_control_register;
  assign accumulation_count_field = accumulation_control_register[3:0];
  assign clock_divider_field = clk_cfg[3:0];
  assign us_ticks = clk_cfg[15:8];
  // timebase below 2 means fewer than two peripheral cycles per microsecond
  assign slow_clk = (us_ticks < `ACS_SLOW_MHZ);
  assign cfg_wr = wr && (addr == `ACS_REG_MAIN);
  // divider starts on the edge that opens sampling, so the window is exact
  assign run_div = (state != ST_IDLE) &&
                   (state != ST_INIT || (init_done && !init_start));

  acs_clkdiv u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(run_div),
    .divider(clock_divider_field),
    .half_tick(half_tick),
    .phase(phase)
  );

  acs_init_timer u_init (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(init_start),
    .need(need),
    .us_ticks(us_ticks),
    .slow_clk(slow_clk),
    .done(init_done)
  );

  // modules the present configuration uses, minus those already warm
  always @* begin
    need = 5'h00;
    need[0] = 1'b1;
    need[1] = main_control_register[`ACS_MAIN_AMP];
    need[2] = main_control_register[`ACS_MAIN_REFINT];
    need[3] = (in_sel == `ACS_IN_TEMP);
    need[4] = (in_sel == `ACS_IN_DAC);
    if (keep_warm_bit && !first)
      need = need & ~warm_set;
  end

  // per-mode timing figures
  always @* begin
    // sampling in half cycles: field plus one half
    samp_halves = {sample_length_field, 1'b1};
    if (main_control_register[`ACS_MAIN_AMP])
      samp_halves = {amp_hold_length_field, 1'b1};
    if (mode == `ACS_MODE_S8)
      conv_cycles = {1'b0, `ACS_CONV_S8};
    else
      conv_cycles = {1'b0, `ACS_CONV_OTHER};
    is_acc = (mode == `ACS_MODE_SERIES) || (mode == `ACS_MODE_BURST);
    if (accumulation_count_field > `ACS_ACC_MAX_LOG)
      acc_total = 11'h400;
    else
      acc_total = 11'h001 << accumulation_count_field;
  end

  // main sequencer
  always @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      half_cnt <= 9'h000;
      init_start <= 1'b0;
      first <= 1'b1;
      warm_set <= 5'h00;
      converter_busy_flag <= 1'b0;
      result_ready <= 1'b0;
      sample_hold <= 1'b0;
      amp_hold <= 1'b0;
      power_en <= 5'h00;
      acc <= 24'h000000;
      acc_left <= 11'h000;
      result <= 24'h000000;
    end else begin
      init_start <= 1'b0;
      result_ready <= 1'b0;
      if (!main_control_register[`ACS_MAIN_EN]) begin
        first <= 1'b1;
        warm_set <= 5'h00;
      end
      case (state)
        ST_IDLE: begin
          sample_hold <= 1'b0;
          amp_hold <= 1'b0;
          if (!keep_warm_bit) begin
            power_en <= 5'h00;
            warm_set <= 5'h00;
          end
          if (trigger && main_control_register[`ACS_MAIN_EN]) begin
            converter_busy_flag <= 1'b1;
            power_en <= power_en | need;
            init_start <= 1'b1;
            // a pending series keeps its running sum
            if (!(is_acc && acc_left != 11'h000)) begin
              acc <= 24'h000000;
              acc_left <= is_acc ? acc_total : 11'h001;
            end
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          converter_busy_flag <= 1'b1;
          if (init_done && !init_start) begin
            first <= 1'b0;
            warm_set <= power_en;
            half_cnt <= samp_halves;
            sample_hold <= 1'b1;
            amp_hold <= main_control_register[`ACS_MAIN_AMP];
            state <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (half_tick) begin
            if (half_cnt <= 9'h001) begin
              sample_hold <= 1'b0;
              amp_hold <= 1'b0; // amplifier back to tracking
              half_cnt <= {3'h0, conv_cycles, 1'b0};
              state <= ST_CONV;
            end else begin
              half_cnt <= half_cnt - 9'h001;
            end
          end
        end
        ST_CONV: begin
          if (half_tick) begin
            if (half_cnt == 9'h001) begin
              half_cnt <= 9'h001;
              state <= ST_LAT;
            end else begin
              half_cnt <= half_cnt - 9'h001;
            end
          end
        end
        ST_LAT: begin
          // half a converter cycle before the main clock step
          if (half_tick)
            state <= ST_MAIN;
        end
        ST_MAIN: begin
          acc <= acc + {12'h000, sample_in};
          acc_left <= acc_left - 11'h001;
          if (is_acc && acc_left == 11'h001) begin
            state <= ST_ACC;
          end else if (acc_left == 11'h001) begin
            result <= {12'h000, sample_in};
            acc_left <= {10'h000, continuous_conversion_bit};
            converter_busy_flag <= continuous_conversion_bit;
            result_ready <= 1'b1;
            state <= continuous_conversion_bit ? ST_INIT : ST_IDLE;
            init_start <= continuous_conversion_bit;
          end else if (mode == `ACS_MODE_BURST) begin
            half_cnt <= samp_halves;
            sample_hold <= 1'b1;
            state <= ST_SAMP;
          end else begin
            state <= ST_IDLE; // series waits for next trigger
          end
        end
        ST_ACC: begin
          result <= acc;
          converter_busy_flag <= continuous_conversion_bit;
          result_ready <= 1'b1;
          acc <= 24'h000000;
          // nothing left pending unless the next run starts at once
          acc_left <= continuous_conversion_bit ? acc_total : 11'h000;
          init_start <= continuous_conversion_bit;
          state <= continuous_conversion_bit ? ST_INIT : ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_IDLE && acc_left != 11'h000 && is_acc &&
          !trigger)
        converter_busy_flag <= 1'b1; // series pending keeps busy
    end
  end

  // register writes
  always @(posedge clk_sys) begin
    if (rst) begin
      main_control_register <= `ACS_MAIN_RST;
      sampling_control_register <= `ACS_SAMP_RST;
      accumulation_control_register <= `ACS_ACC_RST;
      amplifier_control_register <= `ACS_AMP_RST;
      clk_cfg <= `ACS_CLK_RST;
    end else if (wr) begin
      case (addr)
        `ACS_REG_MAIN: main_control_register <= wdata;
        `ACS_REG_SAMP: sampling_control_register <= wdata[7:0];
        `ACS_REG_ACC: accumulation_control_register <= wdata[7:0];
        `ACS_REG_AMP: amplifier_control_register <= wdata[7:0];
        `ACS_REG_CLK: clk_cfg <= wdata;
        default: clk_cfg <= clk_cfg;
      endcase
    end
  end

  // read data one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst || !rd) begin
      rdata <= 16'h0000;
    end else begin
      case (addr)
        `ACS_REG_MAIN: rdata <= main_control_register;
        `ACS_REG_SAMP: rdata <= {8'h00, sampling_control_register};
        `ACS_REG_ACC: rdata <= {8'h00, accumulation_control_register};
        `ACS_REG_AMP: rdata <= {8'h00, amplifier_control_register};
        `ACS_REG_CLK: rdata <= clk_cfg;
        `ACS_REG_STAT: rdata <= {9'h000, state[6:1] != 6'h00,
                                 cfg_wr, phase, 3'h0,
                                 converter_busy_flag};
        `ACS_REG_RESULT: rdata <= result[15:0];
        default: rdata <= {8'h00, result[23:16]};
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/acs_defines.vh ***
// constants for the conversion timing sequencer
//
// Functional notes
// - enable only modules the configuration uses; init ends when slowest finishes.
// - init times: core 10us, amp 10us, reference 60us, sensor 35us, dac 35us.
// - below 2 MHz peripheral clock, core init lasts 20 peripheral cycles.
// - keep-warm leaves modules powered, no init before next conversion.
// - keep-warm still inits on first enable and on new input or reference.
// - busy flag is high while module initialization runs.
// - sampling lasts sample length plus one half converter clock cycles.
// - amplifier samples continuously, holds only while converter samples it.
// - amplifier input sampling lasts at least sample length plus one cycle; code samples for amplifier hold length plus one half instead.
// - accumulation count allows up to 1024 samples, up to 22-bit results.
// - conversion state lasts nine cycles in single 8-bit, else thirteen.
// - results appear half a converter clock plus one main clock later.
// - accumulation modes add one more main clock for the final result.
// - single conversion takes init plus sample length plus 15 or 11 cycles.
// - continuous bit starts next conversion as soon as a result is ready.
// - each series sample takes init plus sample length plus 15 cycles.
// - converter clock divides the peripheral clock by a programmable divider.
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// register indices
`define ACS_REG_MAIN 3'h0
`define ACS_REG_SAMP 3'h1
`define ACS_REG_ACC 3'h2
`define ACS_REG_AMP 3'h3
`define ACS_REG_CLK 3'h4
`define ACS_REG_STAT 3'h5
`define ACS_REG_RESULT 3'h6
`define ACS_REG_CMD 3'h7
// main control fields
`define ACS_MAIN_EN 0
`define ACS_MAIN_WARM 1
`define ACS_MAIN_AMP 2
`define ACS_MAIN_MODE_LO 4
`define ACS_MAIN_MODE_HI 6
`define ACS_MAIN_INSEL_LO 8
`define ACS_MAIN_INSEL_HI 9
`define ACS_MAIN_REFINT 10
// accumulation control fields
`define ACS_ACC_FREE 4
// modes
`define ACS_MODE_S8 3'h0
`define ACS_MODE_S12 3'h1
`define ACS_MODE_SERIES 3'h2
`define ACS_MODE_BURST 3'h4
// input selects
`define ACS_IN_PIN 2'h0
`define ACS_IN_TEMP 2'h1
`define ACS_IN_DAC 2'h2
// initialization times in microseconds
`define ACS_T_CORE_US 8'd10
`define ACS_T_AMP_US 8'd10
`define ACS_T_REF_US 8'd60
`define ACS_T_TEMP_US 8'd35
`define ACS_T_DAC_US 8'd35
// slow clock rule
`define ACS_SLOW_MHZ 2
`define ACS_SLOW_CORE_CYC 16'd20
// conversion state lengths in converter cycles, and log2 of the largest accumulation count
`define ACS_CONV_S8 4'd9
`define ACS_CONV_OTHER 4'd13
`define ACS_ACC_MAX_LOG 4'd10
// reset values
`define ACS_MAIN_RST 16'h0000
`define ACS_SAMP_RST 8'h02
`define ACS_ACC_RST 8'h00
`define ACS_AMP_RST 8'h02
`define ACS_CLK_RST 16'h0a00
`endif

// *** rtl/acs_clkdiv.v ***
// converter clock divider producing half-cycle phase strobes
`timescale 1ns/100ps
`default_nettype none
module acs_clkdiv (
  input wire clk_sys,
  input wire rst,
  input wire run,
  input wire [3:0] divider,
  output reg half_tick,
  output reg phase
);
  reg [3:0] cnt;
  // one strobe each half converter cycle, divider+1 peripheral cycles apart
  always @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt <= 4'h0;
      half_tick <= 1'b0;
      phase <= 1'b0;
    end else if (cnt == divider) begin
      cnt <= 4'h0;
      half_tick <= 1'b1;
      phase <= ~phase;
    end else begin
      cnt <= cnt + 4'h1;
      half_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/acs_init_timer.v ***
// parallel initialization timers, one per analog module
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.vh"
module acs_init_timer (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [4:0] need,
  input wire [7:0] us_ticks,
  input wire slow_clk,
  output reg done
);
  // module order: core, amp, reference, sensor, dac
  wire [39:0] us_tab;
  reg [7:0] us_cnt;
  wire [4:0] busy;
  wire us_tick;
  assign us_tab = {`ACS_T_DAC_US, `ACS_T_TEMP_US, `ACS_T_REF_US,
                   `ACS_T_AMP_US, `ACS_T_CORE_US};
  assign us_tick = (us_cnt >= us_ticks - 8'h01);
  // microsecond timebase from the peripheral clock
  always @(posedge clk_sys) begin
    if (rst || start || us_tick)
      us_cnt <= 8'h00;
    else
      us_cnt <= us_cnt + 8'h01;
  end
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_mod
      reg [15:0] left;
      reg on;
      // one driver per busy bit
      assign busy[i] = on;
      // each needed module counts down on its own, all in parallel
      always @(posedge clk_sys) begin
        if (rst) begin
          left <= 16'h0000;
          on <= 1'b0;
        end else if (start) begin
          on <= need[i];
          if (i == 0 && slow_clk)
            left <= `ACS_SLOW_CORE_CYC;
          else
            left <= {8'h00, us_tab[i*8 +: 8]};
        end else if (on && left == 16'h0000) begin
          on <= 1'b0;
        end else if (on && (us_tick || (i == 0 && slow_clk))) begin
          left <= left - 16'h0001;
        end
      end
    end
  endgenerate
  // done once the slowest enabled module has finished
  always @(posedge clk_sys) begin
    if (rst || start)
      done <= 1'b0;
    else
      done <= (busy == 5'h00);
  end
endmodule
`default_nettype wire

// *** bench/acs_sequencer_sva.sv ***
// assertions on the conversion timing sequencer ports
`timescale 1ns/100ps
`default_nettype none
module acs_seq_sva (
  input wire clk_sys,
  input wire rst,
  input wire [2:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire converter_busy_flag,
  input wire result_ready,
  input wire sample_hold,
  input wire amp_hold,
  input wire [4:0] power_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg [7:0] s_len;
  reg [7:0] h_len;
  reg amp_on;
  reg [3:0] div;
  reg [15:0] hold_cnt;
  // shadow copies of the fields that set the sampling length
  always @(posedge clk_sys)
    if (rst) s_len <= 8'h02;
    else if (wr && addr == 3'h1) s_len <= wdata[7:0];
  always @(posedge clk_sys)
    if (rst) h_len <= 8'h02;
    else if (wr && addr == 3'h3) h_len <= wdata[7:0];
  always @(posedge clk_sys)
    if (rst) amp_on <= 1'b0;
    else if (wr && addr == 3'h0) amp_on <= wdata[2];
  always @(posedge clk_sys)
    if (rst) div <= 4'h0;
    else if (wr && addr == 3'h4) div <= wdata[3:0];
  // cycles spent in the current sampling window
  always @(posedge clk_sys)
    if (rst || !sample_hold) hold_cnt <= 16'h0000;
    else hold_cnt <= hold_cnt + 16'h0001;
  // length plus a half converter cycle, in system clocks
  wire [31:0] exp_len = {7'h00, amp_on ? h_len : s_len, 1'b1} *
    ({12'h000, div} + 16'h0001);
  a_amp_in_sample: assert property (amp_hold |-> sample_hold)
    else $error("amplifier hold outside sampling");
  a_busy_in_sample: assert property (sample_hold |-> converter_busy_flag)
    else $error("sampling while not busy");
  a_core_on_start: assert property ($rose(converter_busy_flag) |-> power_en[0])
    else $error("core not powered at start");
  a_ready_one_cycle: assert property (result_ready |=> !result_ready)
    else $error("result ready longer than one cycle");
  a_busy_drop_ready: assert property ($fell(converter_busy_flag) |->
    (result_ready || $past(result_ready)))
    else $error("busy dropped without a result");
  a_rdata_quiet: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside a read");
  a_status_busy: assert property (rd && addr == 3'h5 |=>
    rdata[0] == $past(converter_busy_flag))
    else $error("status busy bit wrong");
  a_sample_len: assert property ($fell(sample_hold) |->
    hold_cnt == exp_len[15:0])
    else $error("sampling window length wrong");
endmodule
bind acs_sequencer acs_seq_sva chk_u (.clk_sys(clk_sys), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .converter_busy_flag(converter_busy_flag), .result_ready(result_ready),
  .sample_hold(sample_hold), .amp_hold(amp_hold), .power_en(power_en));
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the conversion timing sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic trigger = 1'b0;
  logic [11:0] sample_in = 12'h5a3;
  wire [15:0] rdata;
  wire converter_busy_flag, result_ready, sample_hold, amp_hold;
  wire [4:0] power_en;
  int mismatches = 0;
  int samples_checked = 0;
  int t_init, t_samp, t_conv;
  logic [4:0] pw;
  logic bz;
  logic [15:0] rv;
  logic [15:0] rst_val [0:5] = '{16'h0000, 16'h0002, 16'h0000, 16'h0002,
    16'h0a00, 16'h0000};
  acs_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .trigger(trigger),
    .sample_in(sample_in), .rdata(rdata),
    .converter_busy_flag(converter_busy_flag), .result_ready(result_ready),
    .sample_hold(sample_hold), .amp_hold(amp_hold), .power_en(power_en));
  // 100 mhz system clock
  always #5 clk_sys = ~clk_sys;
  // compare one value and count it
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // step to just after the next edge so outputs have settled
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_rdy;
    int n = 0;
    while (result_ready !== 1'b1 && n < 70000) begin
      tick;
      n++;
    end
    check(n < 70000, 1);
  endtask
  // one trigger pulse, then time init, sampling and conversion
  task automatic run_conv;
    @(posedge clk_sys);
    trigger <= 1'b1;
    @(posedge clk_sys);
    trigger <= 1'b0;
    t_init = 0;
    t_samp = 0;
    t_conv = 0;
    #1 pw = power_en;
    bz = converter_busy_flag;
    while (sample_hold !== 1'b1 && t_init < 2000) begin
      tick;
      t_init++;
    end
    while (sample_hold === 1'b1 && t_samp < 2000) begin
      tick;
      t_samp++;
    end
    while (result_ready !== 1'b1 && t_conv < 70000) begin
      tick;
      t_conv++;
    end
  endtask
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      rd_reg(3'(i), rv);
      check(rv, rst_val[i]);
    end
    wr_reg(3'h6, 16'hffff);
    rd_reg(3'h6, rv);
    check(rv, 16'h0000);
  endtask
  task automatic cfg_run(input logic [15:0] m, c, input logic [4:0] p,
    input int i, s, v);
    wr_reg(3'h4, c);
    wr_reg(3'h0, m);
    run_conv;
    check(bz, 1);
    check(pw, p);
    check(t_init >= i && t_init <= i + 4, 1);
    check(t_samp, s);
    check(t_conv, v);
    repeat (3) tick;
    check(power_en, 5'h00);
    check(converter_busy_flag, 0);
    wr_reg(3'h0, 16'h0000);
  endtask
  // two triggered samples summed in series mode
  task automatic t_series;
    wr_reg(3'h2, 16'h0001);
    sample_in <= 12'h100;
    wr_reg(3'h0, 16'h0021);
    @(posedge clk_sys);
    trigger <= 1'b1;
    @(posedge clk_sys);
    trigger <= 1'b0;
    #1;
    while (sample_hold !== 1'b1 && t_init < 2000) begin
      tick;
      t_init++;
    end
    while (sample_hold === 1'b1 && t_samp < 2000) begin
      tick;
      t_samp++;
    end
    repeat (40) tick;
    check(result_ready, 0);
    check(converter_busy_flag, 1);
    run_conv;
    check(t_init >= 100 && t_init <= 104, 1);
    check(t_samp, 25);
    rd_reg(3'h6, rv);
    check(rv, 16'h0200);
    repeat (3) tick;
    check(converter_busy_flag, 0);
    wr_reg(3'h0, 16'h0000);
    wr_reg(3'h2, 16'h0000);
  endtask
  task automatic t_warm;
    wr_reg(3'h0, 16'h0013);
    run_conv;
    check(t_init >= 100 && t_init <= 104, 1);
    repeat (3) tick;
    check(power_en, 5'h01);
    run_conv;
    check(t_init <= 4, 1);
    wr_reg(3'h0, 16'h0513);
    run_conv;
    check(t_init >= 600 && t_init <= 604, 1);
    wr_reg(3'h0, 16'h0000);
  endtask
  task automatic t_free;
    wr_reg(3'h2, 16'h0010);
    wr_reg(3'h0, 16'h0011);
    run_conv;
    tick;
    tick;
    check(converter_busy_flag, 1);
    rd_reg(3'h5, rv);
    check(rv[0], 1);
    wait_rdy;
    wr_reg(3'h2, 16'h0000);
    wait_rdy;
    repeat (3) tick;
    check(converter_busy_flag, 0);
    rd_reg(3'h6, rv);
    check(rv, 16'h05a3);
    wr_reg(3'h0, 16'h0000);
  endtask
  task automatic t_burst(input logic [15:0] acc, input logic [11:0] smp,
    input logic [15:0] lo, hi);
    wr_reg(3'h2, acc);
    sample_in <= smp;
    wr_reg(3'h0, 16'h0041);
    run_conv;
    check(t_conv < 70000, 1);
    rd_reg(3'h6, rv);
    check(rv, lo);
    rd_reg(3'h7, rv);
    check(rv, hi);
    wr_reg(3'h0, 16'h0000);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    wr_reg(3'h1, 16'h000c);
    wr_reg(3'h3, 16'h0003);
    cfg_run(16'h0011, 16'h0a00, 5'h01, 100, 25, 28);
    cfg_run(16'h0001, 16'h0a00, 5'h01, 100, 25, 20);
    cfg_run(16'h0511, 16'h0a00, 5'h0d, 600, 25, 28);
    cfg_run(16'h0211, 16'h0a00, 5'h11, 350, 25, 28);
    cfg_run(16'h0015, 16'h0a00, 5'h03, 100, 7, 28);
    cfg_run(16'h0011, 16'h0100, 5'h01, 20, 25, 28);
    cfg_run(16'h0041, 16'h0a00, 5'h01, 100, 25, 29);
    t_warm;
    t_free;
    t_series;
    t_burst(16'h0002, 12'h123, 16'h048c, 16'h0000);
    t_burst(16'h000a, 12'hfff, 16'hfc00, 16'h003f);
    print_verdict;
  end
  // cut a hung run short
  initial begin
    #950000;
    mismatches++;
    print_verdict;
  end
endmodule
`default_nettype wire
